// [pcm_pkg.sv]
// Package of constants and types for the power, clock and mode controller
package pcm_pkg;

   // Power modes
   typedef enum logic [3:0] {
      PCM_RUN     = 4'h1,
      PCM_SLEEP   = 4'h2,
      PCM_DEEP    = 4'h4,
      PCM_STANDBY = 4'h8
   } pcm_mode_t;

   // Requested low-power mode encoding
   localparam logic [1:0] PCM_REQ_SLEEP   = 2'h1;
   localparam logic [1:0] PCM_REQ_DEEP    = 2'h2;
   localparam logic [1:0] PCM_REQ_STANDBY = 2'h3;

   // System clock source encoding
   localparam logic [1:0] PCM_SRC_FAST_RC  = 2'h0;
   localparam logic [1:0] PCM_SRC_FAST_XTL = 2'h1;
   localparam logic [1:0] PCM_SRC_PLL      = 2'h2;

   // Boot source encoding
   localparam logic [1:0] PCM_BOOT_FLASH1 = 2'h0;
   localparam logic [1:0] PCM_BOOT_FLASH2 = 2'h1;
   localparam logic [1:0] PCM_BOOT_SYSMEM = 2'h2;
   localparam logic [1:0] PCM_BOOT_SRAM   = 2'h3;

   // Boot pin encodings: pin0 low selects flash
   localparam logic [1:0] PCM_PINS_SYSMEM = 2'h1;
   localparam logic [1:0] PCM_PINS_SRAM   = 2'h3;

   // Bus clock limit and prescaler field
   localparam int unsigned PCM_BUS_MAX_MHZ = 72;
   localparam int unsigned PCM_DIV_W       = 4;

   // Reset stretch after supply loss, reset sources and standby wake
   localparam int unsigned PCM_RST_NS      = 1000;
   localparam int unsigned PCM_CLK_NS      = 25;
   localparam int unsigned PCM_RST_CYC     = (PCM_RST_NS + PCM_CLK_NS - 1) / PCM_CLK_NS;
   localparam int unsigned PCM_RST_W       = 8;

   localparam int unsigned PCM_EXT_LINES   = 16;

endpackage

// [pcm_clk_div.sv]
// Programmable clock divider producing a one-cycle enable pulse
`timescale 1ns/10ps
module pcm_clk_div
   import pcm_pkg::*;
#(
   parameter int unsigned W = PCM_DIV_W
) (
   input  wire logic         i_mclk,
   input  wire logic         i_reset,
   input  wire logic         i_run,
   input  wire logic [W-1:0] i_div,
   output logic              o_tick
);

   logic [W-1:0] count;

   // Divide by i_div plus one; zero passes every edge
   always_ff @(posedge i_mclk) begin
      if (i_reset || !i_run) begin
         count  <= '0;
         o_tick <= 1'b0;
      end else if (count >= i_div) begin
         count  <= '0;
         o_tick <= 1'b1;
      end else begin
         count  <= count + 1'b1;
         o_tick <= 1'b0;
      end
   end

endmodule

// [pcm_power_ctrl.sv]
// Power, reset, wake and boot source control of the device
`timescale 1ns/10ps
module pcm_power_ctrl
   import pcm_pkg::*;
#(
   parameter int unsigned LINES   = PCM_EXT_LINES,
   parameter int unsigned DIV_W   = PCM_DIV_W,
   parameter int unsigned SYS_MHZ = 40
) (
   input  wire logic             i_mclk,
   input  wire logic             i_reset,
   input  wire logic             i_sleep_req,
   input  wire logic [1:0]       i_sleep_mode,
   input  wire logic             i_core_irq,
   input  wire logic [LINES-1:0] i_ext_line,
   input  wire logic             i_rtc_alarm,
   input  wire logic             i_usb_wake,
   input  wire logic             i_droop_raw,
   input  wire logic             i_supply_low_raw,
   input  wire logic             i_reset_pin_n_raw,
   input  wire logic             i_watchdog_rst,
   input  wire logic             i_wake_pin_raw,
   input  wire logic [1:0]       i_boot_pins_raw,
   input  wire logic             i_opt_bank2,
   input  wire logic             i_soft_rst,
   input  wire logic [1:0]       i_clk_src_sel,
   input  wire logic [DIV_W-1:0] i_ahb_div,
   input  wire logic [DIV_W-1:0] i_apb_fast_div,
   input  wire logic [DIV_W-1:0] i_apb_slow_div,
   output logic                  o_core_clk_en,
   output logic                  o_periph_clk_en,
   output logic                  o_fast_rc_en,
   output logic                  o_fast_xtl_en,
   output logic                  o_pll_en,
   output logic                  o_regulator_en,
   output logic                  o_core_pwr_en,
   output logic [1:0]            o_sys_clk_src,
   output logic                  o_core_rst,
   output logic                  o_periph_rst,
   output logic                  o_droop_irq,
   output logic [1:0]            o_boot_src,
   output logic                  o_ahb_tick,
   output logic                  o_apb_fast_tick,
   output logic                  o_apb_slow_tick,
   output logic                  o_div_limited
);

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   localparam int unsigned SW = LINES + 7;
   logic [SW-1:0] sync1;
   logic [SW-1:0] sync2;
   always_ff @(posedge i_mclk) begin
      sync1 <= {i_ext_line, i_droop_raw, i_supply_low_raw, i_reset_pin_n_raw,
                i_wake_pin_raw, i_boot_pins_raw, i_usb_wake};
      sync2 <= sync1;
   end
   logic [LINES-1:0] ext_line;
   logic             droop, supply_low, reset_pin_n, wake_pin, usb_wake;
   logic [1:0]       boot_pins;
   assign {ext_line, droop, supply_low, reset_pin_n, wake_pin, boot_pins, usb_wake} = sync2;

   logic wake_pin_d;
   always_ff @(posedge i_mclk) begin
      wake_pin_d <= wake_pin;
   end

   // ------------------------------------------------------------
   // Mode sequencing
   // ------------------------------------------------------------
   pcm_mode_t mode, next_mode;
   logic      deep_wake, standby_wake, sleep_wake;

   assign sleep_wake   = i_core_irq || (|ext_line) || i_rtc_alarm;
   assign deep_wake    = (|ext_line) || i_rtc_alarm || droop || usb_wake;
   assign standby_wake = !reset_pin_n || i_rtc_alarm || i_watchdog_rst
                         || (wake_pin && !wake_pin_d);

   always_comb begin
      next_mode = mode;
      case (mode)
         PCM_RUN: begin
            if (i_sleep_req) begin
               case (i_sleep_mode)
                  PCM_REQ_SLEEP:   next_mode = PCM_SLEEP;
                  PCM_REQ_DEEP:    next_mode = PCM_DEEP;
                  PCM_REQ_STANDBY: next_mode = PCM_STANDBY;
                  default:         next_mode = PCM_RUN;
               endcase
            end
         end
         PCM_SLEEP: begin
            if (sleep_wake) begin
               next_mode = PCM_RUN;
            end
         end
         PCM_DEEP: begin
            if (deep_wake) begin
               next_mode = PCM_RUN;
            end
         end
         PCM_STANDBY: begin
            if (standby_wake) begin
               next_mode = PCM_RUN;
            end
         end
         default: next_mode = PCM_RUN;
      endcase
   end

   // Supply loss and reset overrule any mode
   always_ff @(posedge i_mclk) begin
      if (i_reset || supply_low) begin
         mode <= PCM_RUN;
      end else begin
         mode <= next_mode;
      end
   end

   // ------------------------------------------------------------
   // Reset generation
   // ------------------------------------------------------------
   logic [PCM_RST_W-1:0] rst_cnt;
   logic                 rst_start;
   // Power-down detection has no disable path
   assign rst_start = supply_low || !reset_pin_n || i_watchdog_rst || i_soft_rst
                      || (mode == PCM_STANDBY && standby_wake);

   always_ff @(posedge i_mclk) begin
      if (i_reset || rst_start) begin
         rst_cnt <= PCM_RST_W'(PCM_RST_CYC);
      end else if (rst_cnt != '0) begin
         rst_cnt <= rst_cnt - 1'b1;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_reset) begin
         o_core_rst   <= 1'b1;
         o_periph_rst <= 1'b1;
      end else begin
         o_core_rst   <= rst_start || rst_cnt != '0;
         o_periph_rst <= rst_start || rst_cnt != '0;
      end
   end

   // Boot source is captured while reset is held
   always_ff @(posedge i_mclk) begin
      if (i_reset) begin
         o_boot_src <= PCM_BOOT_FLASH1;
      end else if (o_core_rst) begin
         if (!boot_pins[0]) begin
            o_boot_src <= i_opt_bank2 ? PCM_BOOT_FLASH2 : PCM_BOOT_FLASH1;
         end else if (boot_pins == PCM_PINS_SRAM) begin
            o_boot_src <= PCM_BOOT_SRAM;
         end else begin
            o_boot_src <= PCM_BOOT_SYSMEM;
         end
      end
   end

   // ------------------------------------------------------------
   // Clock and power enables
   // ------------------------------------------------------------
   always_ff @(posedge i_mclk) begin
      if (i_reset) begin
         o_core_clk_en   <= 1'b1;
         o_periph_clk_en <= 1'b1;
         o_fast_rc_en    <= 1'b1;
         o_fast_xtl_en   <= 1'b0;
         o_pll_en        <= 1'b0;
         o_regulator_en  <= 1'b1;
         o_core_pwr_en   <= 1'b1;
      end else begin
         o_core_clk_en   <= next_mode == PCM_RUN;
         o_periph_clk_en <= next_mode inside {PCM_RUN, PCM_SLEEP};
         o_fast_rc_en    <= next_mode inside {PCM_RUN, PCM_SLEEP};
         o_fast_xtl_en   <= next_mode inside {PCM_RUN, PCM_SLEEP}
                            && i_clk_src_sel != PCM_SRC_FAST_RC;
         o_pll_en        <= next_mode inside {PCM_RUN, PCM_SLEEP}
                            && i_clk_src_sel == PCM_SRC_PLL;
         o_regulator_en  <= next_mode != PCM_STANDBY;
         o_core_pwr_en   <= next_mode != PCM_STANDBY;
      end
   end

   // Source follows software only in run mode without a sleep request; deep-sleep exit and reset force fast RC
   always_ff @(posedge i_mclk) begin
      if (i_reset || o_core_rst) begin
         o_sys_clk_src <= PCM_SRC_FAST_RC;
      end else if (mode == PCM_DEEP && next_mode == PCM_RUN) begin
         o_sys_clk_src <= PCM_SRC_FAST_RC;
      end else if (mode == PCM_RUN && !i_sleep_req) begin
         o_sys_clk_src <= i_clk_src_sel;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_reset) begin
         o_droop_irq <= 1'b0;
      end else begin
         o_droop_irq <= droop;
      end
   end

   // ------------------------------------------------------------
   // Bus clock prescalers
   // ------------------------------------------------------------
   localparam int unsigned MIN_DIV = (SYS_MHZ + PCM_BUS_MAX_MHZ - 1) / PCM_BUS_MAX_MHZ - 1;
   localparam logic [DIV_W-1:0] MIN_DIV_V = DIV_W'(MIN_DIV);

   function automatic logic [DIV_W-1:0] clamp_div(input logic [DIV_W-1:0] d);
      clamp_div = (d < MIN_DIV_V) ? MIN_DIV_V : d;
   endfunction

   logic [DIV_W-1:0] ahb_div, apb_fast_div;
   assign ahb_div      = clamp_div(i_ahb_div);
   assign apb_fast_div = clamp_div(i_apb_fast_div);

   always_ff @(posedge i_mclk) begin
      if (i_reset) begin
         o_div_limited <= 1'b0;
      end else begin
         o_div_limited <= (ahb_div != i_ahb_div) || (apb_fast_div != i_apb_fast_div);
      end
   end

   pcm_clk_div #(.W(DIV_W)) u_ahb_div (
      .i_mclk  (i_mclk),
      .i_reset (i_reset),
      .i_run   (o_periph_clk_en),
      .i_div   (ahb_div),
      .o_tick  (o_ahb_tick)
   );
   pcm_clk_div #(.W(DIV_W)) u_apb_fast_div (
      .i_mclk  (i_mclk),
      .i_reset (i_reset),
      .i_run   (o_periph_clk_en),
      .i_div   (apb_fast_div),
      .o_tick  (o_apb_fast_tick)
   );
   pcm_clk_div #(.W(DIV_W)) u_apb_slow_div (
      .i_mclk  (i_mclk),
      .i_reset (i_reset),
      .i_run   (o_periph_clk_en),
      .i_div   (i_apb_slow_div),
      .o_tick  (o_apb_slow_tick)
   );

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   sequence deep_exit_s;
      mode == PCM_DEEP && next_mode == PCM_RUN;
   endsequence

   sleep_gating_a: assert property (@(posedge i_mclk) disable iff (i_reset)
      mode == PCM_SLEEP |-> !o_core_clk_en && o_periph_clk_en)
      else $error("sleep clock gating wrong");
   sleep_wake_a: assert property (@(posedge i_mclk) disable iff (i_reset)
      mode == PCM_SLEEP && sleep_wake && !supply_low |=> mode == PCM_RUN)
      else $error("sleep did not end on event");
   deep_clocks_a: assert property (@(posedge i_mclk) disable iff (i_reset)
      mode == PCM_DEEP |-> !o_fast_rc_en && !o_fast_xtl_en && !o_pll_en)
      else $error("oscillators running in deep-sleep");
   deep_bus_a: assert property (@(posedge i_mclk) disable iff (i_reset)
      !o_periph_clk_en |=> !o_ahb_tick && !o_apb_fast_tick && !o_apb_slow_tick)
      else $error("bus clocks running while stopped");
   deep_wake_a: assert property (@(posedge i_mclk) disable iff (i_reset)
      mode == PCM_DEEP && usb_wake && !supply_low |=> mode == PCM_RUN)
      else $error("deep-sleep missed wake");
   deep_exit_src_a: assert property (@(posedge i_mclk) disable iff (i_reset)
      deep_exit_s and !o_core_rst |=> o_sys_clk_src == PCM_SRC_FAST_RC)
      else $error("clock source not fast RC after deep-sleep");
   standby_pwr_a: assert property (@(posedge i_mclk) disable iff (i_reset)
      mode == PCM_STANDBY |-> !o_regulator_en && !o_core_pwr_en)
      else $error("core powered in standby");
   standby_rst_a: assert property (@(posedge i_mclk) disable iff (i_reset)
      mode == PCM_STANDBY && standby_wake |=> o_core_rst [*3])
      else $error("standby wake without reset");
   supply_hold_a: assert property (@(posedge i_mclk) disable iff (i_reset)
      supply_low |=> o_core_rst && o_periph_rst)
      else $error("reset released under low supply");
   droop_irq_a: assert property (@(posedge i_mclk) disable iff (i_reset)
      droop |=> o_droop_irq)
      else $error("droop warning missing");
   boot_bank_a: assert property (@(posedge i_mclk) disable iff (i_reset)
      o_core_rst && !boot_pins[0] && i_opt_bank2 |=> o_boot_src == PCM_BOOT_FLASH2)
      else $error("bank two not chosen");
   bus_limit_a: assert property (@(posedge i_mclk) disable iff (i_reset)
      ahb_div >= MIN_DIV_V && apb_fast_div >= MIN_DIV_V)
      else $error("fast bus over limit");

endmodule

// [pcm_far_side.sv]
// Model of the core and wake-source peripherals facing the controller
`timescale 1ns/10ps
module pcm_far_side
   import pcm_pkg::*;
(
   input  wire logic        i_mclk,
   input  wire logic [2:0]  i_go_mode,
   input  wire logic [2:0]  i_go_wake,
   input  wire logic [1:0]  i_boot_sel,
   input  wire logic        i_core_clk_en,
   input  wire logic        i_core_rst,
   output logic             o_sleep_req,
   output logic [1:0]       o_sleep_mode,
   output logic             o_core_irq,
   output logic [15:0]      o_ext_line,
   output logic             o_rtc_alarm,
   output logic             o_usb_wake,
   output logic             o_reset_pin_n,
   output logic             o_watchdog_rst,
   output logic             o_wake_pin,
   output logic [1:0]       o_boot_pins
);
   initial begin
      {o_sleep_req, o_sleep_mode, o_core_irq, o_ext_line, o_rtc_alarm} = '0;
      {o_usb_wake, o_watchdog_rst, o_wake_pin, o_boot_pins} = '0;
      o_reset_pin_n = 1'b1;
   end
   always @(posedge i_mclk) begin
      // A halted core cannot keep asking, so the request drops with its clock
      o_sleep_req    <= i_go_mode[2] && i_core_clk_en && !i_core_rst;
      o_sleep_mode   <= i_go_mode[1:0];
      o_core_irq     <= (i_go_wake == 3'h1);
      o_ext_line     <= {(i_go_wake == 3'h2), 15'h0000};
      o_rtc_alarm    <= (i_go_wake == 3'h3);
      o_usb_wake     <= (i_go_wake == 3'h4);
      o_reset_pin_n  <= (i_go_wake != 3'h5);
      o_watchdog_rst <= (i_go_wake == 3'h6);
      o_wake_pin     <= (i_go_wake == 3'h7);
      o_boot_pins    <= i_boot_sel;
   end
endmodule

// [test_pcm_power_ctrl.sv]
// Self-checking bench of the power, clock and mode controller
`timescale 1ns/10ps
module test_pcm_power_ctrl
   import pcm_pkg::*;
;
   typedef struct {logic [2:0] mode; logic [2:0] wake; logic [6:0] en; logic rst;} pcm_row_t;
   logic             i_mclk = 1'b0;
   logic             i_reset = 1'b1;
   logic [2:0]       go_mode = 3'h0;
   logic [2:0]       go_wake = 3'h0;
   logic [1:0]       boot_sel = 2'h0;
   logic             droop = 1'b0;
   logic             supply_low = 1'b0;
   logic             opt_bank2 = 1'b0;
   logic             soft_rst = 1'b0;
   logic [1:0]       clk_sel = 2'h0;
   logic [3:0]       ahb_div = 4'h0;
   logic [3:0]       apb_fast_div = 4'h0;
   logic [3:0]       apb_slow_div = 4'h0;
   logic             sleep_req, core_irq, rtc_alarm, usb_wake, pin_n, wdg_rst, wake_pin;
   logic [1:0]       sleep_mode, boot_pins;
   logic [15:0]      ext_line;
   logic             o_core_clk_en, o_periph_clk_en, o_fast_rc_en, o_fast_xtl_en, o_pll_en;
   logic             o_regulator_en, o_core_pwr_en, o_core_rst, o_periph_rst, o_droop_irq;
   logic             o_ahb_tick, o_apb_fast_tick, o_apb_slow_tick, o_div_limited;
   logic [1:0]       o_sys_clk_src, o_boot_src;
   logic [6:0]       en_now;
   int               fail_count = 0;
   int               checks_done = 0;
   int               n, ta, tf, ts;
   pcm_row_t         rows [11];

   assign en_now = {o_core_clk_en, o_periph_clk_en, o_fast_rc_en, o_fast_xtl_en, o_pll_en,
                    o_regulator_en, o_core_pwr_en};

   initial begin
      forever #12.5 i_mclk = ~i_mclk;
   end

   pcm_far_side pcm_far_side_inst (.i_mclk(i_mclk), .i_go_mode(go_mode), .i_go_wake(go_wake),
      .i_boot_sel(boot_sel), .i_core_clk_en(o_core_clk_en), .i_core_rst(o_core_rst),
      .o_sleep_req(sleep_req), .o_sleep_mode(sleep_mode), .o_core_irq(core_irq),
      .o_ext_line(ext_line), .o_rtc_alarm(rtc_alarm), .o_usb_wake(usb_wake),
      .o_reset_pin_n(pin_n), .o_watchdog_rst(wdg_rst), .o_wake_pin(wake_pin),
      .o_boot_pins(boot_pins));

   pcm_power_ctrl pcm_power_ctrl_inst (.i_mclk(i_mclk), .i_reset(i_reset),
      .i_sleep_req(sleep_req), .i_sleep_mode(sleep_mode), .i_core_irq(core_irq),
      .i_ext_line(ext_line), .i_rtc_alarm(rtc_alarm), .i_usb_wake(usb_wake),
      .i_droop_raw(droop), .i_supply_low_raw(supply_low), .i_reset_pin_n_raw(pin_n),
      .i_watchdog_rst(wdg_rst), .i_wake_pin_raw(wake_pin), .i_boot_pins_raw(boot_pins),
      .i_opt_bank2(opt_bank2), .i_soft_rst(soft_rst), .i_clk_src_sel(clk_sel),
      .i_ahb_div(ahb_div), .i_apb_fast_div(apb_fast_div), .i_apb_slow_div(apb_slow_div),
      .o_core_clk_en(o_core_clk_en), .o_periph_clk_en(o_periph_clk_en),
      .o_fast_rc_en(o_fast_rc_en), .o_fast_xtl_en(o_fast_xtl_en), .o_pll_en(o_pll_en),
      .o_regulator_en(o_regulator_en), .o_core_pwr_en(o_core_pwr_en),
      .o_sys_clk_src(o_sys_clk_src), .o_core_rst(o_core_rst), .o_periph_rst(o_periph_rst),
      .o_droop_irq(o_droop_irq), .o_boot_src(o_boot_src), .o_ahb_tick(o_ahb_tick),
      .o_apb_fast_tick(o_apb_fast_tick), .o_apb_slow_tick(o_apb_slow_tick),
      .o_div_limited(o_div_limited));

   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Waits on core clock (0), core reset (1) or droop flag (2)
   task automatic wait_on(input int sel, input logic val, input int bound);
      logic s;
      for (int k = 0; k < bound; k++) begin
         @(negedge i_mclk);
         s = (sel == 0) ? o_core_clk_en : (sel == 1) ? o_core_rst : o_droop_irq;
         if (s === val) return;
      end
      fail_count++;
      $display("unexpected at %0t: wait %h ran out", $time, sel);
      give_verdict();
   endtask

   task automatic rst_seq();
      @(posedge i_mclk);
      i_reset <= 1'b1;
      repeat (9) @(posedge i_mclk);
      @(negedge i_mclk);
      check({o_core_rst, o_periph_rst, o_droop_irq}, 3'h6);
      check({o_sys_clk_src, o_regulator_en}, 3'h1);
      @(posedge i_mclk);
      i_reset <= 1'b0;
      n = 0;
      while (o_core_rst === 1'b1 && n < 100) begin
         @(negedge i_mclk);
         n++;
      end
      check(n >= PCM_RST_CYC && n <= PCM_RST_CYC + 2, 1'b1);
      $display("reset sequence done");
   endtask

   task automatic count_ticks(input int cyc);
      ta = 0;
      tf = 0;
      ts = 0;
      repeat (cyc) begin
         @(negedge i_mclk);
         ta += int'(o_ahb_tick === 1'b1);
         tf += int'(o_apb_fast_tick === 1'b1);
         ts += int'(o_apb_slow_tick === 1'b1);
      end
   endtask

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      rows = '{'{3'h5, 3'h1, 7'h33, 1'b0}, '{3'h5, 3'h2, 7'h33, 1'b0}, '{3'h5, 3'h3, 7'h33, 1'b0},
               '{3'h6, 3'h2, 7'h03, 1'b0}, '{3'h6, 3'h3, 7'h03, 1'b0}, '{3'h6, 3'h4, 7'h03, 1'b0},
               '{3'h7, 3'h5, 7'h00, 1'b1}, '{3'h7, 3'h3, 7'h00, 1'b1}, '{3'h7, 3'h6, 7'h00, 1'b1},
               '{3'h7, 3'h7, 7'h00, 1'b1}, '{3'h4, 3'h0, 7'h73, 1'b0}};
      rst_seq();
      check(o_boot_src, PCM_BOOT_FLASH1);
      for (int i = 0; i < 11; i++) begin
         @(posedge i_mclk);
         go_mode <= rows[i].mode;
         if (rows[i].mode[1:0] == 2'h0) repeat (6) @(negedge i_mclk);
         else wait_on(0, 1'b0, 10);
         @(posedge i_mclk);
         go_mode <= 3'h0;
         repeat (4) @(negedge i_mclk);
         check(en_now, rows[i].en);
         @(posedge i_mclk);
         go_wake <= rows[i].wake;
         wait_on(0, 1'b1, 12);
         check(o_core_rst, rows[i].rst);
         @(posedge i_mclk);
         go_wake <= 3'h0;
         wait_on(1, 1'b0, 100);
         $display("mode row %0d done", i);
      end
      @(posedge i_mclk);
      clk_sel <= PCM_SRC_PLL;
      boot_sel <= PCM_PINS_SYSMEM;
      repeat (6) @(negedge i_mclk);
      check({o_sys_clk_src, o_fast_xtl_en, o_pll_en}, 4'hB);
      @(posedge i_mclk);
      go_mode <= 3'h6;
      wait_on(0, 1'b0, 10);
      @(posedge i_mclk);
      go_mode <= 3'h0;
      @(negedge i_mclk);
      check({o_fast_xtl_en, o_pll_en}, 2'h0);
      @(posedge i_mclk);
      go_wake <= 3'h4;
      wait_on(0, 1'b1, 12);
      check(o_sys_clk_src, PCM_SRC_FAST_RC);
      @(posedge i_mclk);
      go_wake <= 3'h0;
      clk_sel <= PCM_SRC_FAST_RC;
      go_mode <= 3'h7;
      wait_on(0, 1'b0, 10);
      @(posedge i_mclk);
      go_mode <= 3'h0;
      go_wake <= 3'h7;
      wait_on(1, 1'b1, 12);
      @(posedge i_mclk);
      go_wake <= 3'h0;
      wait_on(1, 1'b0, 100);
      check(o_boot_src, PCM_BOOT_SYSMEM);
      $display("deep exit and standby boot done");
      @(posedge i_mclk);
      boot_sel <= 2'h0;
      opt_bank2 <= 1'b1;
      rst_seq();
      check(o_boot_src, PCM_BOOT_FLASH2);
      @(posedge i_mclk);
      boot_sel <= PCM_PINS_SRAM;
      soft_rst <= 1'b1;
      wait_on(1, 1'b1, 6);
      check(o_periph_rst, 1'b1);
      @(posedge i_mclk);
      soft_rst <= 1'b0;
      wait_on(1, 1'b0, 100);
      check(o_boot_src, PCM_BOOT_SRAM);
      @(posedge i_mclk);
      supply_low <= 1'b1;
      wait_on(1, 1'b1, 6);
      repeat (20) @(negedge i_mclk);
      check({o_core_rst, o_periph_rst}, 2'h3);
      @(posedge i_mclk);
      supply_low <= 1'b0;
      droop <= 1'b1;
      wait_on(2, 1'b1, 6);
      @(posedge i_mclk);
      droop <= 1'b0;
      wait_on(2, 1'b0, 6);
      wait_on(1, 1'b0, 100);
      $display("reset and droop done");
      @(posedge i_mclk);
      ahb_div <= 4'h1;
      apb_fast_div <= 4'h2;
      apb_slow_div <= 4'h3;
      repeat (10) @(negedge i_mclk);
      count_ticks(120);
      check(ta >= 59 && ta <= 61 && tf >= 39 && tf <= 41, 1'b1);
      check(ts >= 29 && ts <= 31, 1'b1);
      check(o_div_limited, 1'b0);
      @(posedge i_mclk);
      ahb_div <= 4'h0;
      repeat (10) @(negedge i_mclk);
      count_ticks(120);
      check(ta >= 119, 1'b1);
      $display("prescalers done");
      give_verdict();
   end
endmodule
